// >>> psr_dev.sv
// I/O controller end: PCI I/O target, parity, shared reset pin, ISA clock
//
// Summary of operation
// [RULE1] All PCI signals timed by PCI clock
// [RULE2] ISA clock divided down from PCI clock
// [RULE3] Shared pin: A20 mask or reset by strap
// [RULE4] Reset pulse one millisecond after power-good
// [RULE5] Hot reset bit also fires reset pulse
// [RULE6] Reset-drive bit also fires reset pulse
// [RULE7] PCI reset equals inverted ISA reset
// [RULE8] Address phase with frame, then data phases
// [RULE9] Command in address phase, byte enables after
// [RULE10] Even parity over AD and C/BE lanes
// [RULE11] Address parity valid next clock
// [RULE12] Data parity one clock after ready
// [RULE13] Parity held one clock past completion
// [RULE14] Drive parity on reads, check on writes
// [RULE15] Initiator frames transaction, drops for last
// [RULE16] I/O target disconnects after one transfer
// [RULE17] Reset pulse timed by PCI clock counter
`timescale 1ns/10ps
`include "psr_map.svh"
module psr_dev #(
	parameter logic [31:0] IO_BASE  = `PSR_IO_BASE,
	parameter int unsigned RST_CYC  = `PSR_RST_CYC,
	parameter int unsigned ISA_HALF = `PSR_ISA_HALF_DIV
) (
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	psr_if.dev               bus,
	input  wire logic        power_good_in_i,
	input  wire logic        cpu_mode_strap_i,
	input  wire logic        a20_mask_req_n_i,
	input  wire logic        hot_reset_set_i,
	input  wire logic        reset_drive_set_i,
	input  wire logic [31:0] rd_data_i,
	output logic             rd_stb_o,
	output logic             wr_stb_o,
	output logic [31:0]      wr_data_o,
	output logic [3:0]       wr_be_n_o,
	output logic             parity_err_o,
	output logic             x86_mode_o,
	output logic             bus_reset_out_n_o,
	output logic             isa_reset_o,
	output logic             isa_clk_o
);

	psr_pkg::psr_dev_state_e state_q;
	logic        frame_prev_n_q;
	logic        is_write_q;
	logic        chk_pend_q;
	logic        chk_par_q;
	logic        devsel_n_q;
	logic        trdy_n_q;
	logic        stop_n_q;
	logic        perr_n_q;
	logic [31:0] ad_q;
	logic        ad_oe_n_q;
	logic        par_q;
	logic        par_oe_n_q;
	logic        addr_start;
	logic        addr_hit;
	logic        xfer;
	logic        strap_taken_q;
	logic        nonx86_q;
	logic        pg_q;
	logic        rdrv_q;
	logic [31:0] rst_cnt_q;
	logic        rst_fire;
	logic [31:0] isa_cnt_q;
	logic        isa_clk_q;

	////////////////////////////////////////////////////////////////////////////
	// Target decode and data phase

	// [RULE8] address phase is first frame-low clock
	assign addr_start = !bus.frame_n && frame_prev_n_q;
	// [RULE9] command lanes decoded in address phase only
	assign addr_hit   = addr_start && (bus.ad[31:2] == IO_BASE[31:2]) &&
	                    ((bus.cbe_n == `PSR_CMD_IO_RD) || (bus.cbe_n == `PSR_CMD_IO_WR));
	assign xfer       = (state_q == psr_pkg::DEV_DATA) && !bus.irdy_n && !trdy_n_q;

	// [RULE1] bus sampled on every rising PCI clock edge
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			frame_prev_n_q <= `PSR_PIN_HIGH;
		end else begin
			frame_prev_n_q <= bus.frame_n;
		end
	end

	// Target state machine
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_q    <= psr_pkg::DEV_IDLE;
			is_write_q <= 1'b0;
			devsel_n_q <= 1'b1;
			trdy_n_q   <= 1'b1;
			stop_n_q   <= 1'b1;
			ad_q       <= `PSR_AD_IDLE;
			ad_oe_n_q  <= 1'b1;
		end else begin
			case (state_q)
				psr_pkg::DEV_IDLE: begin
					if (addr_hit) begin
						state_q    <= psr_pkg::DEV_DATA;
						is_write_q <= (bus.cbe_n == `PSR_CMD_IO_WR);
						devsel_n_q <= 1'b0;
						trdy_n_q   <= 1'b0;
						// [RULE16] stop with first ready: no I/O bursts
						stop_n_q   <= 1'b0;
						ad_q       <= rd_data_i;
						ad_oe_n_q  <= (bus.cbe_n == `PSR_CMD_IO_WR);
					end
				end
				psr_pkg::DEV_DATA: begin
					// Waits for initiator ready; frame already released
					if (xfer) begin
						state_q    <= psr_pkg::DEV_TAIL;
						devsel_n_q <= 1'b1;
						trdy_n_q   <= 1'b1;
						stop_n_q   <= 1'b1;
						ad_oe_n_q  <= 1'b1;
					end
				end
				psr_pkg::DEV_TAIL: begin
					state_q <= psr_pkg::DEV_IDLE;
				end
				default: begin
					state_q <= psr_pkg::DEV_IDLE;
				end
			endcase
		end
	end

	// User strobes, one clock each
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rd_stb_o  <= 1'b0;
			wr_stb_o  <= 1'b0;
			wr_data_o <= 32'h0000_0000;
			wr_be_n_o <= 4'hF;
		end else begin
			rd_stb_o <= xfer && !is_write_q;
			wr_stb_o <= xfer && is_write_q;
			if (xfer && is_write_q) begin
				wr_data_o <= bus.ad;
				wr_be_n_o <= bus.cbe_n;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Parity drive and check

	// [RULE14] drive parity only for read data we supply
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			par_q      <= 1'b0;
			par_oe_n_q <= 1'b1;
		end else if ((state_q == psr_pkg::DEV_DATA) && !is_write_q) begin
			// [RULE12] valid the clock after ready is shown
			par_q      <= psr_pkg::psr_parity(ad_q, bus.cbe_n);
			par_oe_n_q <= 1'b0;
		end else begin
			// [RULE13] the tail clock keeps the last value
			par_oe_n_q <= 1'b1;
		end
	end

	// [RULE10] write data checked against even parity next clock
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			chk_pend_q <= 1'b0;
			chk_par_q  <= 1'b0;
			perr_n_q   <= 1'b1;
		end else begin
			chk_pend_q <= xfer && is_write_q;
			if (xfer && is_write_q) begin
				chk_par_q <= psr_pkg::psr_parity(bus.ad, bus.cbe_n);
			end
			perr_n_q <= !(chk_pend_q && (bus.par != chk_par_q));
		end
	end

	assign parity_err_o     = !perr_n_q;
	assign bus.perr_n       = perr_n_q;
	assign bus.devsel_n     = devsel_n_q;
	assign bus.trdy_n       = trdy_n_q;
	assign bus.stop_n       = stop_n_q;
	assign bus.dev_ad       = ad_q;
	assign bus.dev_ad_oe_n  = ad_oe_n_q;
	assign bus.dev_par      = par_q;
	assign bus.dev_par_oe_n = par_oe_n_q;

	////////////////////////////////////////////////////////////////////////////
	// Mode strap and reset pulse

	// Strap caught on the first clock after reset release
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			strap_taken_q <= 1'b0;
			nonx86_q      <= 1'b0;
		end else if (!strap_taken_q) begin
			strap_taken_q <= 1'b1;
			nonx86_q      <= cpu_mode_strap_i;
		end
	end

	// [RULE4] power-good rising edge, [RULE6] reset-drive rising edge
	assign rst_fire = (power_good_in_i && !pg_q) || hot_reset_set_i || (reset_drive_set_i && !rdrv_q);

	// [RULE17] pulse length counted in PCI clocks
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pg_q      <= 1'b0;
			rdrv_q    <= 1'b0;
			rst_cnt_q <= 32'h0000_0000;
		end else begin
			pg_q   <= power_good_in_i;
			rdrv_q <= reset_drive_set_i;
			// [RULE5] hot reset set restarts the full pulse
			if (rst_fire) begin
				rst_cnt_q <= 32'(RST_CYC);
			end else if (rst_cnt_q != 32'h0000_0000) begin
				rst_cnt_q <= rst_cnt_q - 32'h0000_0001;
			end
		end
	end

	// [RULE7] one source, so both resets move together
	assign isa_reset_o       = !power_good_in_i || (rst_cnt_q != 32'h0000_0000);
	assign bus_reset_out_n_o = !isa_reset_o;
	assign x86_mode_o        = !nonx86_q;
	// [RULE3] pin function follows the latched strap
	assign bus.addr_bit20_mask_n = nonx86_q ? bus_reset_out_n_o : a20_mask_req_n_i;

	////////////////////////////////////////////////////////////////////////////
	// ISA clock divider

	// [RULE2] ISA clock from PCI clock, no separate source
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			isa_cnt_q <= 32'h0000_0000;
			isa_clk_q <= 1'b0;
		end else if (isa_cnt_q >= 32'(ISA_HALF - 1)) begin
			isa_cnt_q <= 32'h0000_0000;
			isa_clk_q <= !isa_clk_q;
		end else begin
			isa_cnt_q <= isa_cnt_q + 32'h0000_0001;
		end
	end

	assign isa_clk_o = isa_clk_q;

endmodule

// >>> psr_host.sv
// Host bridge end: single-word PCI initiator with parity
`timescale 1ns/10ps
`include "psr_map.svh"
module psr_host #(
	parameter int unsigned ABORT_CYC = `PSR_ABORT_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	psr_if.host              bus,
	input  wire logic        pin_is_reset_i,
	input  wire logic        req_i,
	input  wire logic        req_write_i,
	input  wire logic [31:0] req_addr_i,
	input  wire logic [31:0] req_wdata_i,
	input  wire logic [3:0]  req_be_n_i,
	output logic             ready_o,
	output logic             done_o,
	output logic             abort_o,
	output logic             rd_perr_o,
	output logic [31:0]      rdata_o
);

	psr_pkg::psr_hst_state_e state_q;
	logic        bus_rst;
	logic        xfer;
	logic        wr_q;
	logic [31:0] wdata_q;
	logic [3:0]  be_n_q;
	logic [31:0] wait_cnt_q;
	logic        aborted_q;
	logic        frame_n_q;
	logic        irdy_n_q;
	logic [3:0]  cbe_n_q;
	logic [31:0] ad_q;
	logic        ad_oe_n_q;
	logic        par_q;
	logic        par_oe_n_q;
	logic        exp_par_q;

	////////////////////////////////////////////////////////////////////////////
	// Bus reset and request handshake

	// Shared pin resets this end only when the strap gives it that role
	assign bus_rst = sys_rst_i || (pin_is_reset_i && !bus.addr_bit20_mask_n);
	assign ready_o = (state_q == psr_pkg::HST_IDLE) && !bus_rst;
	assign xfer    = (state_q == psr_pkg::HST_DATA) && !bus.trdy_n;

	// [RULE15] frame only in the address phase: one data phase
	always_ff @(posedge clk_i) begin
		if (bus_rst) begin
			state_q    <= psr_pkg::HST_IDLE;
			wr_q       <= 1'b0;
			wdata_q    <= 32'h0000_0000;
			be_n_q     <= 4'hF;
			wait_cnt_q <= 32'h0000_0000;
			aborted_q  <= 1'b0;
			frame_n_q  <= 1'b1;
			irdy_n_q   <= 1'b1;
			cbe_n_q    <= 4'hF;
			ad_q       <= `PSR_AD_IDLE;
			ad_oe_n_q  <= 1'b1;
		end else begin
			case (state_q)
				psr_pkg::HST_IDLE: begin
					if (req_i) begin
						state_q   <= psr_pkg::HST_ADDR;
						wr_q      <= req_write_i;
						wdata_q   <= req_wdata_i;
						be_n_q    <= req_be_n_i;
						aborted_q <= 1'b0;
						// [RULE8] address on the lanes with frame
						frame_n_q <= 1'b0;
						ad_q      <= req_addr_i;
						ad_oe_n_q <= 1'b0;
						// [RULE9] command on the byte-enable lanes
						cbe_n_q   <= req_write_i ? `PSR_CMD_IO_WR : `PSR_CMD_IO_RD;
					end
				end
				psr_pkg::HST_ADDR: begin
					state_q    <= psr_pkg::HST_DATA;
					frame_n_q  <= 1'b1;
					irdy_n_q   <= 1'b0;
					cbe_n_q    <= be_n_q;
					ad_q       <= wdata_q;
					// Reads hand the lanes to the target
					ad_oe_n_q  <= !wr_q;
					wait_cnt_q <= 32'h0000_0000;
				end
				psr_pkg::HST_DATA: begin
					// Give up when no target claims the cycle in time
					if (xfer || (bus.devsel_n && (wait_cnt_q >= 32'(ABORT_CYC - 1)))) begin
						state_q   <= psr_pkg::HST_TAIL;
						irdy_n_q  <= 1'b1;
						ad_oe_n_q <= 1'b1;
						aborted_q <= !xfer;
					end else if (bus.devsel_n) begin
						wait_cnt_q <= wait_cnt_q + 32'h0000_0001;
					end
				end
				psr_pkg::HST_TAIL: begin
					state_q <= psr_pkg::HST_IDLE;
				end
				default: begin
					state_q <= psr_pkg::HST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Parity drive and read check

	// [RULE10] [RULE11] address parity on the clock after address
	always_ff @(posedge clk_i) begin
		if (bus_rst) begin
			par_q      <= 1'b0;
			par_oe_n_q <= 1'b1;
		end else if (state_q == psr_pkg::HST_ADDR) begin
			par_q      <= psr_pkg::psr_parity(ad_q, cbe_n_q);
			par_oe_n_q <= 1'b0;
		end else if (state_q == psr_pkg::HST_DATA) begin
			// [RULE12] write parity follows ready; reads leave the pin
			par_q      <= psr_pkg::psr_parity(wdata_q, be_n_q);
			par_oe_n_q <= !wr_q;
		end else begin
			// [RULE13] released after the clock past completion
			par_oe_n_q <= 1'b1;
		end
	end

	// [RULE14] read data taken, its parity checked a clock later
	always_ff @(posedge clk_i) begin
		if (bus_rst) begin
			done_o    <= 1'b0;
			abort_o   <= 1'b0;
			rd_perr_o <= 1'b0;
			rdata_o   <= 32'h0000_0000;
			exp_par_q <= 1'b0;
		end else begin
			done_o <= (state_q == psr_pkg::HST_TAIL);
			if (xfer && !wr_q) begin
				rdata_o   <= bus.ad;
				exp_par_q <= psr_pkg::psr_parity(bus.ad, bus.cbe_n);
			end
			if (state_q == psr_pkg::HST_TAIL) begin
				abort_o   <= aborted_q;
				rd_perr_o <= !wr_q && !aborted_q && (bus.par != exp_par_q);
			end
		end
	end

	assign bus.frame_n       = frame_n_q;
	assign bus.irdy_n        = irdy_n_q;
	assign bus.cbe_n         = cbe_n_q;
	assign bus.host_ad       = ad_q;
	assign bus.host_ad_oe_n  = ad_oe_n_q;
	assign bus.host_par      = par_q;
	assign bus.host_par_oe_n = par_oe_n_q;

endmodule

// >>> psr_if.sv
// Bus wiring between the PCI host end and the I/O controller end
`timescale 1ns/10ps
`include "psr_map.svh"
interface psr_if;
	logic        frame_n;
	logic        irdy_n;
	logic [3:0]  cbe_n;
	logic [31:0] host_ad;
	logic        host_ad_oe_n;
	logic        host_par;
	logic        host_par_oe_n;
	logic        devsel_n;
	logic        trdy_n;
	logic        stop_n;
	logic        perr_n;
	logic [31:0] dev_ad;
	logic        dev_ad_oe_n;
	logic        dev_par;
	logic        dev_par_oe_n;
	logic        addr_bit20_mask_n;
	logic [31:0] ad;
	logic        par;

	// Shared lanes resolved from the enables; undriven lanes float high
	assign ad  = !host_ad_oe_n ? host_ad : (!dev_ad_oe_n ? dev_ad : `PSR_AD_IDLE);
	assign par = !host_par_oe_n ? host_par : (!dev_par_oe_n ? dev_par : `PSR_PIN_HIGH);

	modport dev (
		input  frame_n, irdy_n, cbe_n, ad, par,
		output devsel_n, trdy_n, stop_n, perr_n, dev_ad, dev_ad_oe_n, dev_par, dev_par_oe_n,
		output addr_bit20_mask_n
	);

	modport host (
		input  devsel_n, trdy_n, stop_n, perr_n, ad, par, addr_bit20_mask_n,
		output frame_n, irdy_n, cbe_n, host_ad, host_ad_oe_n, host_par, host_par_oe_n
	);
endinterface

// >>> psr_map.svh
// Constants for the PCI signal interface and reset generator
`ifndef PSR_MAP_SVH
`define PSR_MAP_SVH

// PCI bus commands used by the I/O target
`define PSR_CMD_IO_RD      4'h2
`define PSR_CMD_IO_WR      4'h3
`define PSR_CMD_W          4
`define PSR_BE_ALL_N       4'h0

// Bus idle levels
`define PSR_AD_IDLE        32'hFFFF_FFFF
`define PSR_PIN_HIGH       1'b1

// Clock and reset timing
`define PSR_CLK_PERIOD_NS  20
`define PSR_RST_PULSE_NS   1000000
`define PSR_RST_CYC        ((`PSR_RST_PULSE_NS + `PSR_CLK_PERIOD_NS - 1) / `PSR_CLK_PERIOD_NS)

// Default ISA clock divide ratio, half period in PCI clocks
`define PSR_ISA_HALF_DIV   2

// Default target I/O word address
`define PSR_IO_BASE        32'h0000_0400

// PCI clocks without device select before the host gives up
`define PSR_ABORT_CYC      5

`endif

// >>> psr_pkg.sv
// Types and helpers shared by both ends of the PCI signal interface
package psr_pkg;

	typedef enum logic [1:0] {
		DEV_IDLE,
		DEV_DATA,
		DEV_TAIL
	} psr_dev_state_e;

	typedef enum logic [1:0] {
		HST_IDLE,
		HST_ADDR,
		HST_DATA,
		HST_TAIL
	} psr_hst_state_e;

	// Even parity over address/data and command/byte-enable lanes
	function automatic logic psr_parity(input logic [31:0] ad, input logic [3:0] cbe_n);
		psr_parity = ^{ad, cbe_n};
	endfunction

endpackage

// >>> psr_props.sv
// Concurrent checks on the PCI wires between host and controller ends
`timescale 1ns/10ps
`include "psr_map.svh"
module psr_props (
	input wire logic        clk_i,
	input wire logic        sys_rst_i,
	input wire logic        frame_n,
	input wire logic        irdy_n,
	input wire logic        trdy_n,
	input wire logic        devsel_n,
	input wire logic        host_ad_oe_n,
	input wire logic        dev_ad_oe_n,
	input wire logic [3:0]  cbe_n,
	input wire logic [31:0] ad,
	input wire logic        par
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// Parity lags its lanes by one clock, so compare against the past values
	par_addr_a: assert property ($fell(frame_n) |=> par == ^{$past(ad), $past(cbe_n)})
		else $error("address parity wrong");
	par_data_a: assert property (!irdy_n && !trdy_n |=> par == ^{$past(ad), $past(cbe_n)})
		else $error("data parity wrong");
	no_clash_a: assert property (host_ad_oe_n || dev_ad_oe_n)
		else $error("both ends drive the lanes");
	addr_drive_a: assert property ($fell(frame_n) |-> !host_ad_oe_n)
		else $error("address not driven by host");
	cmd_lane_a: assert property ($fell(frame_n) |-> cbe_n inside {`PSR_CMD_IO_RD, `PSR_CMD_IO_WR})
		else $error("bad command on lanes");
	one_xfer_a: assert property (!irdy_n && !trdy_n |=> trdy_n)
		else $error("target ready held past one transfer");
	last_phase_a: assert property (!irdy_n && !trdy_n |-> frame_n)
		else $error("frame held in final phase");
	devsel_first_a: assert property (!trdy_n |-> !devsel_n)
		else $error("target ready without device select");
endmodule

// >>> test_pci_signal_interface_reset.sv
// Self-checking bench joining the host end and the controller end
`timescale 1ns/10ps
`include "psr_map.svh"
module test_pci_signal_interface_reset;
	localparam int RST = 50;
	typedef struct packed {logic wr; logic [31:0] data; logic [3:0] be_n;} psr_row_s;
	logic        clk_i = 1'b0, sys_rst_i = 1'b1, pg = 1'b0, strap = 1'b1, a20 = 1'b1, hot = 1'b0, drv = 1'b0;
	logic        req = 1'b0, req_wr = 1'b0, rd_stb, wr_stb, perr, x86, rst_n, isa_rst, isa_clk;
	logic        ready, done, abort, rd_perr;
	logic [31:0] rd_data = 32'h0, wdata = 32'h0, wr_data, rdata, seen_wd, addr = `PSR_IO_BASE;
	logic [3:0]  be_n = 4'h0, wr_be_n, seen_be;
	int          error_cnt = 0, num_checks = 0;
	psr_row_s    rows [4] = '{'{1'b1, 32'hA5A5_0001, 4'h0}, '{1'b1, 32'h0000_FFFF, 4'hA},
	                          '{1'b0, 32'h1234_5678, 4'h0}, '{1'b0, 32'hFFFF_0000, 4'h0}};
	psr_if psr_if_inst ();
	psr_dev #(.RST_CYC(RST), .ISA_HALF(2)) psr_dev_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus(psr_if_inst),
		.power_good_in_i(pg), .cpu_mode_strap_i(strap), .a20_mask_req_n_i(a20), .hot_reset_set_i(hot),
		.reset_drive_set_i(drv), .rd_data_i(rd_data), .rd_stb_o(rd_stb), .wr_stb_o(wr_stb), .wr_data_o(wr_data),
		.wr_be_n_o(wr_be_n), .parity_err_o(perr), .x86_mode_o(x86), .bus_reset_out_n_o(rst_n),
		.isa_reset_o(isa_rst), .isa_clk_o(isa_clk));
	psr_host psr_host_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus(psr_if_inst), .pin_is_reset_i(strap),
		.req_i(req), .req_write_i(req_wr), .req_addr_i(addr), .req_wdata_i(wdata), .req_be_n_i(be_n),
		.ready_o(ready), .done_o(done), .abort_o(abort), .rd_perr_o(rd_perr), .rdata_o(rdata));
	psr_props psr_props_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .frame_n(psr_if_inst.frame_n),
		.irdy_n(psr_if_inst.irdy_n), .trdy_n(psr_if_inst.trdy_n), .devsel_n(psr_if_inst.devsel_n),
		.host_ad_oe_n(psr_if_inst.host_ad_oe_n), .dev_ad_oe_n(psr_if_inst.dev_ad_oe_n),
		.cbe_n(psr_if_inst.cbe_n), .ad(psr_if_inst.ad), .par(psr_if_inst.par));
	////////////////////////////////////////////////////////////////////////////////
	// Clock and capture of write strobes, held since the strobe lasts one cycle
	always #10 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		if (wr_stb === 1'b1) begin
			seen_wd <= wr_data;
			seen_be <= wr_be_n;
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick();
		@(posedge clk_i);
		#2;
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// One host transfer; bounded waits so a stuck handshake cannot hang the run
	task automatic xfer(input psr_row_s r, input logic ab);
		int n;
		n = 0;
		while (ready !== 1'b1 && n < 50) begin tick(); n++; end
		{req_wr, wdata, be_n} = r;
		rd_data = r.data;
		req = 1'b1;
		tick();
		req = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 50) begin tick(); n++; end
		chk("done", 1, done);
		chk("abort", ab, abort);
		if (!r.wr && !ab) chk("rdata", r.data, rdata);
		chk("rd_perr", 0, rd_perr);
	endtask
	// Fire one reset source and measure the pulse in clocks
	task automatic pulse(input int k);
		int n;
		n = 0;
		if (k == 0) pg = 1'b1; else if (k == 1) hot = 1'b1; else drv = 1'b1;
		tick();
		{hot, drv} = 2'b00;
		while (rst_n !== 1'b0 && n < 10) begin tick(); n++; end
		n = 0;
		while (rst_n === 1'b0 && n < RST + 10) begin
			chk("isa_rst", 1, isa_rst);
			chk("pin_low", 0, psr_if_inst.addr_bit20_mask_n);
			tick();
			n++;
		end
		chk("pulse_len", 1, n >= RST && n <= RST + 2);
		chk("isa_rst_off", 0, isa_rst);
		chk("pin_rst", 1, psr_if_inst.addr_bit20_mask_n);
		$display("test pulse %0d done", k);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: reset pulses, table of transfers, ISA clock, x86 pin mode
	initial begin
		int n;
		logic prev;
		repeat (16) tick();
		sys_rst_i = 1'b0;
		// Strap is latched on the first clock after release
		tick();
		chk("x86_off", 0, x86);
		pulse(0);
		foreach (rows[i]) begin
			xfer(rows[i], 1'b0);
			if (rows[i].wr) chk("wr_data", rows[i].data, seen_wd);
			if (rows[i].wr) chk("wr_be", rows[i].be_n, seen_be);
			chk("perr", 0, perr);
		end
		$display("test transfers done");
		// No target decodes this address, so the host must give up
		addr = `PSR_IO_BASE + 32'h0000_0010;
		xfer(rows[0], 1'b1);
		addr = `PSR_IO_BASE;
		$display("test abort done");
		pulse(1);
		pulse(2);
		n = 0;
		for (int i = 0; i < 40; i++) begin
			prev = isa_clk;
			tick();
			if (isa_clk === 1'b1 && prev === 1'b0) n++;
		end
		chk("isa_edges", 10, n);
		$display("test isa clock done");
		strap = 1'b0;
		sys_rst_i = 1'b1;
		repeat (16) tick();
		sys_rst_i = 1'b0;
		a20 = 1'b0;
		repeat (2) tick();
		chk("x86_on", 1, x86);
		chk("a20_low", 0, psr_if_inst.addr_bit20_mask_n);
		a20 = 1'b1;
		repeat (2) tick();
		chk("a20_high", 1, psr_if_inst.addr_bit20_mask_n);
		$display("test x86 mode done");
		results();
	end
	// Watchdog well past the expected few hundred clocks
	initial begin
		#100000;
		error_cnt++;
		$display("watchdog expired");
		results();
	end
endmodule
